// ===== apr_pkg.sv
package apr_pkg;

	// ------------------------------------------------------------
	// register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CHANNEL_ROUTE      = 8'h35;
	localparam logic [7:0] ADDR_RATE_MONITOR       = 8'h37;
	localparam logic [7:0] ADDR_BITCLK_RATIO_LOW   = 8'h38;
	localparam logic [7:0] ADDR_CLOCK_CHECK_STATUS = 8'h39;
	localparam logic [7:0] ADDR_MASTER_VOLUME      = 8'h4c;
	localparam logic [7:0] ADDR_VOLUME_RAMP_NORMAL = 8'h4e;

	localparam logic [7:0] RST_CHANNEL_ROUTE       = 8'h11;
	localparam logic [1:0] RST_RESERVED_PAIR       = 2'h0;
	localparam logic [7:0] RST_MASTER_VOLUME       = 8'h30;
	localparam logic [7:0] RST_VOLUME_RAMP_NORMAL  = 8'h33;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int LEFT_SRC_LSB   = 4;
	localparam int RIGHT_SRC_LSB  = 0;
	localparam int RSV_HIGH_LSB   = 6;
	localparam int RATIO_HIGH_LSB = 4;
	localparam int FLAG_BCK_RATE  = 5;
	localparam int FLAG_PLL_OVER  = 4;
	localparam int FLAG_PLL_LOCK  = 3;
	localparam int FLAG_BCK_MISS  = 2;
	localparam int FLAG_BCK_VALID = 1;
	localparam int FLAG_RATE_ERR  = 0;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_ZERO  = 2'h0;
	localparam logic [1:0] SRC_OWN   = 2'h1;
	localparam logic [1:0] SRC_OTHER = 2'h2;

	localparam logic [3:0] RATE_ERR     = 4'h0;
	localparam logic [3:0] FS_MODE_AUTO = 4'h0;
	localparam int         RATE_NUM     = 5;
	localparam int         RATE_HZ   [RATE_NUM] = '{8000, 16000, 32000, 48000, 96000};
	localparam logic [3:0] RATE_CODE [RATE_NUM] = '{4'h2, 4'h4, 4'h6, 4'h9, 4'hb};
	localparam int         RATE_TOL_SHIFT = 5;

	localparam logic [7:0] VOL_MUTE        = 8'hff;
	localparam logic [7:0] VOL_STEPS_6DB   = 8'h0c;
	localparam int         VOL_BASE_SHIFT  = 11;
	localparam logic [15:0] VOL_MANT [12] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3,
		16'h65ad, 16'h5ffd, 16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};

	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int WORD_W     = 24;
	localparam int RATIO_W    = 10;
	localparam int HCNT_W     = 6;
	localparam logic [RATIO_W-1:0] RATIO_MIN = 10'h020;
	localparam logic [RATIO_W-1:0] RATIO_MAX = 10'h200;
	localparam int ALIVE_BIT  = 3;

	localparam int CORE_CLK_HZ      = 20_000_000;
	localparam int CORE_CLK_NS      = 50;
	localparam int BCK_MISS_NS      = 20_000;
	localparam int BCK_MISS_CYC     = BCK_MISS_NS / CORE_CLK_NS;
	localparam int FRAME_TIMEOUT_US = 250;
	localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * 1000 / CORE_CLK_NS;

endpackage

// ===== apr_link.sv
`timescale 1ns/1ps
module apr_link (
	// link clock and reset
	input  wire logic                        bclk_i,
	input  wire logic                        reset_i,
	// serial audio
	input  wire logic                        lrclk_i,
	input  wire logic                        sdata_i,
	// frame results, stable between toggles, and a free-running alive bit
	output logic      [apr_pkg::WORD_W-1:0]  left_o,
	output logic      [apr_pkg::WORD_W-1:0]  right_o,
	output logic      [apr_pkg::RATIO_W-1:0] ratio_o,
	output logic                             frame_tgl_o,
	output logic                             alive_o
);

	typedef struct packed {
		logic                         rst_s1;
		logic                         rst_s2;
		logic                         lrck_d;
		logic [apr_pkg::HCNT_W-1:0]   hcnt;
		logic [apr_pkg::RATIO_W-1:0]  fcnt;
		logic [apr_pkg::WORD_W-1:0]   sh;
		logic [apr_pkg::WORD_W-1:0]   left_h;
		logic [apr_pkg::WORD_W-1:0]   left_w;
		logic [apr_pkg::WORD_W-1:0]   right_w;
		logic [apr_pkg::RATIO_W-1:0]  ratio;
		logic                         tgl;
		logic [apr_pkg::ALIVE_BIT:0]  alive;
	} apr_link_st_t;

	apr_link_st_t r;
	apr_link_st_t n;

	// --------------------------------------------------------------
	// frame slicing: frame begins at the falling frame clock edge
	// --------------------------------------------------------------
	always_comb begin
		n        = r;
		n.rst_s1 = reset_i;
		n.rst_s2 = r.rst_s1;
		if (r.rst_s2) begin
			n.lrck_d  = 1'b0;
			n.hcnt    = '0;
			n.fcnt    = '0;
			n.sh      = '0;
			n.left_h  = '0;
			n.left_w  = '0;
			n.right_w = '0;
			n.ratio   = '0;
			n.tgl     = 1'b0;
			n.alive   = '0;
		end else begin
			n.lrck_d = lrclk_i;
			n.alive  = r.alive + 1'b1;
			if (r.fcnt != '1)
				n.fcnt = r.fcnt + 1'b1;
			if (lrclk_i != r.lrck_d) begin
				n.hcnt = 6'h01;
				n.sh   = '0;
				if (lrclk_i) begin
					n.left_h = r.sh;
				end else begin
					// one whole frame seen: publish ratio and words together
					n.left_w  = r.left_h;
					n.right_w = r.sh;
					n.ratio   = r.fcnt;
					n.fcnt    = 10'h001;
					n.tgl     = ~r.tgl;
				end
			end else begin
				if (r.hcnt != '1)
					n.hcnt = r.hcnt + 1'b1;
				if (r.hcnt >= 6'h01 && r.hcnt <= 6'(apr_pkg::WORD_W))
					n.sh = {r.sh[apr_pkg::WORD_W-2:0], sdata_i};
			end
		end
	end

	always_ff @(posedge bclk_i) begin
		r <= n;
	end

	assign left_o      = r.left_w;
	assign right_o     = r.right_w;
	assign ratio_o     = r.ratio;
	assign frame_tgl_o = r.tgl;
	assign alive_o     = r.alive[apr_pkg::ALIVE_BIT];

endmodule // apr_link

// ===== apr_route_clkmon.sv
`timescale 1ns/1ps
// Notes on behaviour
// - left output source: 00 zero, 01 left input, 10 right input; reset left
// - right output source: 00 zero, 01 right input, 10 left input; reset right
// - detected rate code: 0000 error, 2/4/6/9/b for 8/16/32/48/96 kHz
// - top two bits of bit-clock ratio read at rate monitor bits 5 to 4
// - low eight bits of bit clocks per frame read in their own byte
// - status bit 5 flags bit clock ratio above or below allowed range
// - status bit 4 flags PLL running above its allowed rate
// - status bit 3 shows PLL lock, forced unlocked while PLL disabled
// - status bit 2 flags a missing bit clock
// - status bit 1: bit clock ratio stable and within 32 to 512
// - bit 0: rate invalid in auto mode, rate mismatch in fixed mode
// - rate error status still raised while rate errors are ignored
// - one volume code for both channels, +24 dB down to -103 dB, 0.5 dB steps
// - volume code ff mutes both channels
// - ignoring rate errors keeps them out of the clock error output
module apr_route_clkmon #(
	parameter int FRAME_TIMEOUT = apr_pkg::FRAME_TIMEOUT_CYC
) (
	// core clock, reset, enable
	input  wire logic                        CORE_CLK_I,
	input  wire logic                        RESET_I,
	input  wire logic                        CE_I,
	// register port
	input  wire logic [7:0]                  REG_ADDR_I,
	input  wire logic                        REG_WR_I,
	input  wire logic                        REG_RD_I,
	input  wire logic [7:0]                  REG_WDATA_I,
	output logic      [7:0]                  REG_RDATA_O,
	// serial audio link
	input  wire logic                        BCLK_I,
	input  wire logic                        LRCLK_I,
	input  wire logic                        SDATA_I,
	// pll state pins
	input  wire logic                        PLL_EN_I,
	input  wire logic                        PLL_LOCK_I,
	input  wire logic                        PLL_OVER_I,
	// rate configuration from neighbouring logic
	input  wire logic [3:0]                  FS_MODE_I,
	input  wire logic                        IGNORE_RATE_ERROR_I,
	// audio and clock results
	output logic      [apr_pkg::WORD_W-1:0]  LEFT_OUT_O,
	output logic      [apr_pkg::WORD_W-1:0]  RIGHT_OUT_O,
	output logic                             OUT_VALID_O,
	output logic                             CLOCK_ERROR_O,
	output logic      [7:0]                  RAMP_CTRL_O
);

	localparam int W  = apr_pkg::WORD_W;
	localparam int RW = apr_pkg::RATIO_W;

	typedef struct packed {
		logic [7:0]          route;
		logic [1:0]          mon_rsv;
		logic [1:0]          stat_rsv;
		logic [7:0]          vol;
		logic [7:0]          ramp;
		logic [7:0]          rdata;
		logic                tgl_s1;
		logic                tgl_s2;
		logic                tgl_s3;
		logic                alv_s1;
		logic                alv_s2;
		logic                alv_s3;
		logic [2:0]          pll_s1;
		logic [2:0]          pll_s2;
		logic                seen;
		logic [RW-1:0]       ratio;
		logic                stable;
		logic [15:0]         period;
		logic [3:0]          rate_code;
		logic [11:0]         miss_cnt;
		logic                bck_miss;
		logic [1:0][W-1:0]   samp;
		logic                samp_vld;
		logic [W-1:0]        out_l;
		logic [W-1:0]        out_r;
		logic                out_vld;
	} apr_st_t;

	apr_st_t r;
	apr_st_t n;

	logic [W-1:0]  lk_left;
	logic [W-1:0]  lk_right;
	logic [RW-1:0] lk_ratio;
	logic          lk_tgl;
	logic          lk_alive;

	// --------------------------------------------------------------
	// link-clock side: frame slicing and bit clock counting
	// --------------------------------------------------------------
	apr_link u_link (
		.bclk_i      (BCLK_I),
		.reset_i     (RESET_I),
		.lrclk_i     (LRCLK_I),
		.sdata_i     (SDATA_I),
		.left_o      (lk_left),
		.right_o     (lk_right),
		.ratio_o     (lk_ratio),
		.frame_tgl_o (lk_tgl),
		.alive_o     (lk_alive)
	);

	// --------------------------------------------------------------
	// live status, derived straight from detection state
	// --------------------------------------------------------------
	logic       frame_ev;
	logic       bck_out_of_range;
	logic       bck_valid;
	logic       rate_err;
	logic       pll_lock;
	logic [7:0] status;
	logic [7:0] rate_mon;

	assign frame_ev         = r.tgl_s2 ^ r.tgl_s3;
	assign bck_out_of_range = r.seen &&
		(r.ratio < apr_pkg::RATIO_MIN || r.ratio > apr_pkg::RATIO_MAX);
	assign bck_valid        = r.seen && r.stable && !bck_out_of_range && !r.bck_miss;
	assign pll_lock         = r.pll_s2[0] & r.pll_s2[1];
	// fixed rate: flag mismatch; auto: flag an undetected rate
	assign rate_err = (FS_MODE_I == apr_pkg::FS_MODE_AUTO) ?
		(r.rate_code == apr_pkg::RATE_ERR) : (r.rate_code != FS_MODE_I);

	always_comb begin
		status                         = '0;
		status[7:6]                    = r.stat_rsv;
		status[apr_pkg::FLAG_BCK_RATE]  = bck_out_of_range;
		status[apr_pkg::FLAG_PLL_OVER]  = r.pll_s2[2];
		status[apr_pkg::FLAG_PLL_LOCK]  = pll_lock;
		status[apr_pkg::FLAG_BCK_MISS]  = r.bck_miss;
		status[apr_pkg::FLAG_BCK_VALID] = bck_valid;
		status[apr_pkg::FLAG_RATE_ERR]  = rate_err;
		rate_mon       = {r.mon_rsv, r.ratio[RW-1:RW-2], r.rate_code};
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		int            per;
		int            nom;
		int            tol;
		logic [1:0]    sel;
		logic [7:0]    q;
		logic [7:0]    rm;
		logic [15:0]   mant;
		logic signed [W+16:0] prod;
		logic signed [W+16:0] shv;
		logic [W-1:0]  in_w [2];

		per  = 32'(r.period);
		nom  = 0;
		tol  = 0;
		sel  = '0;
		q    = '0;
		rm   = '0;
		mant = '0;
		prod = '0;
		shv  = '0;
		in_w[0] = lk_left;
		in_w[1] = lk_right;
		n    = r;

		if (RESET_I) begin
			n          = '0;
			n.route    = apr_pkg::RST_CHANNEL_ROUTE;
			n.mon_rsv  = apr_pkg::RST_RESERVED_PAIR;
			n.stat_rsv = apr_pkg::RST_RESERVED_PAIR;
			n.vol      = apr_pkg::RST_MASTER_VOLUME;
			n.ramp     = apr_pkg::RST_VOLUME_RAMP_NORMAL;
			n.rate_code = apr_pkg::RATE_ERR;
		end else if (CE_I) begin
			// crossings: level syncs and toggle event
			n.tgl_s1 = lk_tgl;
			n.tgl_s2 = r.tgl_s1;
			n.tgl_s3 = r.tgl_s2;
			n.alv_s1 = lk_alive;
			n.alv_s2 = r.alv_s1;
			n.alv_s3 = r.alv_s2;
			n.pll_s1 = {PLL_OVER_I, PLL_LOCK_I, PLL_EN_I};
			n.pll_s2 = r.pll_s1;

			// register writes
			if (REG_WR_I) begin
				case (REG_ADDR_I)
					apr_pkg::ADDR_CHANNEL_ROUTE:      n.route    = REG_WDATA_I;
					apr_pkg::ADDR_RATE_MONITOR:       n.mon_rsv  = REG_WDATA_I[7:6];
					apr_pkg::ADDR_CLOCK_CHECK_STATUS: n.stat_rsv = REG_WDATA_I[7:6];
					apr_pkg::ADDR_MASTER_VOLUME:      n.vol      = REG_WDATA_I;
					apr_pkg::ADDR_VOLUME_RAMP_NORMAL: n.ramp     = REG_WDATA_I;
					default:                          n.route    = r.route;
				endcase
			end

			// reads only return data, nothing is cleared
			if (REG_RD_I) begin
				case (REG_ADDR_I)
					apr_pkg::ADDR_CHANNEL_ROUTE:      n.rdata = r.route;
					apr_pkg::ADDR_RATE_MONITOR:       n.rdata = rate_mon;
					apr_pkg::ADDR_BITCLK_RATIO_LOW:   n.rdata = r.ratio[7:0];
					apr_pkg::ADDR_CLOCK_CHECK_STATUS: n.rdata = status;
					apr_pkg::ADDR_MASTER_VOLUME:      n.rdata = r.vol;
					apr_pkg::ADDR_VOLUME_RAMP_NORMAL: n.rdata = r.ramp;
					default:                          n.rdata = 8'h00;
				endcase
			end

			// bit clock missing watchdog
			if (r.alv_s2 != r.alv_s3) begin
				n.miss_cnt = '0;
				n.bck_miss = 1'b0;
			end else if (r.miss_cnt >= 12'(apr_pkg::BCK_MISS_CYC - 1)) begin
				n.bck_miss = 1'b1;
			end else begin
				n.miss_cnt = r.miss_cnt + 1'b1;
			end

			// frame period in core cycles gives the sample rate
			if (r.period != '1)
				n.period = r.period + 1'b1;
			if (per >= FRAME_TIMEOUT)
				n.rate_code = apr_pkg::RATE_ERR;

			n.samp_vld = 1'b0;
			if (frame_ev) begin
				n.seen   = 1'b1;
				n.ratio  = lk_ratio;
				n.stable = (lk_ratio == r.ratio);
				n.period = 16'h0001;
				n.rate_code = apr_pkg::RATE_ERR;
				for (int i = 0; i < apr_pkg::RATE_NUM; i++) begin
					nom = apr_pkg::CORE_CLK_HZ / apr_pkg::RATE_HZ[i];
					tol = nom >> apr_pkg::RATE_TOL_SHIFT;
					if (per >= nom - tol && per <= nom + tol)
						n.rate_code = apr_pkg::RATE_CODE[i];
				end
				// routing: channel 0 own input is left, channel 1 own is right
				for (int ch = 0; ch < 2; ch++) begin
					sel = (ch == 0) ? r.route[apr_pkg::LEFT_SRC_LSB +: 2]
					                : r.route[apr_pkg::RIGHT_SRC_LSB +: 2];
					case (sel)
						apr_pkg::SRC_OWN:   n.samp[ch] = in_w[ch];
						apr_pkg::SRC_OTHER: n.samp[ch] = in_w[1-ch];
						// code 11 falls here and gives silence
						default:            n.samp[ch] = '0;
					endcase
				end
				n.samp_vld = 1'b1;
			end

			// volume: 6 dB per shift, 0.5 dB steps from a mantissa table
			n.out_vld = r.samp_vld;
			if (r.samp_vld) begin
				q    = r.vol / apr_pkg::VOL_STEPS_6DB;
				rm   = r.vol % apr_pkg::VOL_STEPS_6DB;
				mant = apr_pkg::VOL_MANT[rm[3:0]];
				for (int ch = 0; ch < 2; ch++) begin
					prod = (W+17)'($signed(r.samp[ch]) * $signed({1'b0, mant}));
					shv  = prod >>> (6'(apr_pkg::VOL_BASE_SHIFT) + q[5:0]);
					if (r.vol == apr_pkg::VOL_MUTE)
						shv = '0;
					else if (shv > $signed((W+17)'({1'b0, {(W-1){1'b1}}})))
						shv = $signed((W+17)'({1'b0, {(W-1){1'b1}}}));
					else if (shv < -$signed((W+17)'({1'b1, {(W-1){1'b0}}})))
						shv = -$signed((W+17)'({1'b1, {(W-1){1'b0}}}));
					if (ch == 0)
						n.out_l = shv[W-1:0];
					else
						n.out_r = shv[W-1:0];
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		r <= n;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign REG_RDATA_O   = r.rdata;
	assign LEFT_OUT_O    = r.out_l;
	assign RIGHT_OUT_O   = r.out_r;
	assign OUT_VALID_O   = r.out_vld;
	assign RAMP_CTRL_O   = r.ramp;
	// an ignored rate error still shows in status but not here
	assign CLOCK_ERROR_O = (rate_err && !IGNORE_RATE_ERROR_I) ||
		r.bck_miss || (r.seen && !bck_valid);

endmodule // apr_route_clkmon

// ===== apr_checker.sv
`timescale 1ns/1ps
module apr_checker #(
	parameter int FRAME_TIMEOUT = 5000
) (
	// core side
	input wire logic        CORE_CLK_I,
	input wire logic        RESET_I,
	input wire logic        CE_I,
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [7:0]  REG_WDATA_I,
	input wire logic [7:0]  REG_RDATA_O,
	input wire logic        PLL_EN_I,
	// results
	input wire logic [23:0] LEFT_OUT_O,
	input wire logic [23:0] RIGHT_OUT_O,
	input wire logic        OUT_VALID_O,
	input wire logic [7:0]  RAMP_CTRL_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	logic       rd;
	logic       wr;
	logic [7:0] vol_r;
	logic [7:0] route_r;
	assign rd = CE_I && REG_RD_I;
	assign wr = CE_I && REG_WR_I;
	// mirrors of the route and volume control bytes
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			vol_r <= 8'h30;
			route_r <= 8'h11;
		end else begin
			if (wr && REG_ADDR_I == 8'h4c)
				vol_r <= REG_WDATA_I;
			if (wr && REG_ADDR_I == 8'h35)
				route_r <= REG_WDATA_I;
		end
	end
	property p_unmapped;
		rd && !(REG_ADDR_I inside {8'h35, 8'h37, 8'h38, 8'h39, 8'h4c, 8'h4e}) |=> REG_RDATA_O == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		!rd |=> $stable(REG_RDATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_vol_rd;
		rd && REG_ADDR_I == 8'h4c |=> REG_RDATA_O == $past(vol_r);
	endproperty
	a_vol_rd: assert property (p_vol_rd) else $error("volume readback wrong");
	property p_route_rd;
		rd && REG_ADDR_I == 8'h35 |=> REG_RDATA_O == $past(route_r);
	endproperty
	a_route_rd: assert property (p_route_rd) else $error("route readback wrong");
	property p_ramp;
		wr && REG_ADDR_I == 8'h4e |=> RAMP_CTRL_O == $past(REG_WDATA_I);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp control not updated");
	property p_pulse;
		OUT_VALID_O |=> !OUT_VALID_O;
	endproperty
	a_pulse: assert property (p_pulse) else $error("sample valid longer than one cycle");
	property p_mute;
		OUT_VALID_O && vol_r == 8'hff && $past(vol_r, 8) == 8'hff |-> LEFT_OUT_O == 24'h0
			&& RIGHT_OUT_O == 24'h0;
	endproperty
	a_mute: assert property (p_mute) else $error("muted output not zero");
	property p_left_zero;
		OUT_VALID_O && route_r[5:4] == 2'h0 && $past(route_r[5:4], 8) == 2'h0 |-> LEFT_OUT_O == 24'h0;
	endproperty
	a_left_zero: assert property (p_left_zero) else $error("left zero source leaks");
	property p_right_zero;
		OUT_VALID_O && route_r[1:0] == 2'h0 && $past(route_r[1:0], 8) == 2'h0 |-> RIGHT_OUT_O == 24'h0;
	endproperty
	a_right_zero: assert property (p_right_zero) else $error("right zero source leaks");
	property p_pll_off;
		(!PLL_EN_I && CE_I)[*6] ##0 (rd && REG_ADDR_I == 8'h39) |=> !REG_RDATA_O[3];
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("disabled pll shown locked");
	c_mute: cover property (OUT_VALID_O && vol_r == 8'hff);
	c_swap: cover property (OUT_VALID_O && route_r == 8'h22);
	c_pll_off: cover property (rd && REG_ADDR_I == 8'h39 && !PLL_EN_I);
endmodule // apr_checker

bind apr_route_clkmon apr_checker #(.FRAME_TIMEOUT(FRAME_TIMEOUT)) u_chk (
	.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O), .PLL_EN_I(PLL_EN_I), .LEFT_OUT_O(LEFT_OUT_O),
	.RIGHT_OUT_O(RIGHT_OUT_O), .OUT_VALID_O(OUT_VALID_O), .RAMP_CTRL_O(RAMP_CTRL_O));

// ===== apr_partner.sv
`timescale 1ns/1ps
module apr_partner (
	// serial audio towards the block
	output logic BCLK_O,
	output logic LRCLK_O,
	output logic SDATA_O
);
	initial begin
		BCLK_O = 1'b1;
		LRCLK_O = 1'b1;
		SDATA_O = 1'b0;
	end
	task automatic pulse(input int k);
		repeat (k) begin
			#24 BCLK_O = 1'b0;
			#24 BCLK_O = 1'b1;
		end
	endtask
	// bit clock runs inside a frame and in pulse() bursts; unused slots carry the inverse bit
	task automatic send_frame(input logic [23:0] l, input logic [23:0] r, input int n);
		int j;
		for (int i = 0; i < n; i++) begin
			j = (i >= n / 2) ? i - n / 2 : i;
			BCLK_O = 1'b0;
			LRCLK_O = (i >= n / 2);
			SDATA_O = (j >= 1 && j <= 24) ? ((i >= n / 2) ? r[24 - j] : l[24 - j]) : ~SDATA_O;
			#24 BCLK_O = 1'b1;
			#24;
		end
	endtask
endmodule // apr_partner

// ===== apr_route_clkmon_tb.sv
`timescale 1ns/1ps
module apr_route_clkmon_tb;
	logic        clk, rst, ce, wr, rd, pll_en, pll_lock, pll_over, ign;
	logic        ovalid, clkerr, bclk, lrclk, sdata, rd_seen;
	logic [7:0]  addr, wdata, rdata, ramp, vol;
	logic [3:0]  mode;
	logic [1:0]  lsrc, rsrc;
	logic [23:0] lo, ro;
	logic [47:0] s;
	logic [7:0]  rq[$];
	logic [47:0] sq[$];
	logic [7:0]  vols[5] = '{8'h00, 8'h18, 8'h3c, 8'hfc, 8'hff};
	logic [31:0] seed = 32'h5d8e99e2;
	int          miscompares = 0;
	int          tests_run = 0;
	apr_route_clkmon #(.FRAME_TIMEOUT(3000)) dut (.CORE_CLK_I(clk), .RESET_I(rst), .CE_I(ce),
		.REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
		.BCLK_I(bclk), .LRCLK_I(lrclk), .SDATA_I(sdata), .PLL_EN_I(pll_en),
		.PLL_LOCK_I(pll_lock), .PLL_OVER_I(pll_over), .FS_MODE_I(mode),
		.IGNORE_RATE_ERROR_I(ign), .LEFT_OUT_O(lo), .RIGHT_OUT_O(ro), .OUT_VALID_O(ovalid),
		.CLOCK_ERROR_O(clkerr), .RAMP_CTRL_O(ramp));
	apr_partner src (.BCLK_O(bclk), .LRCLK_O(lrclk), .SDATA_O(sdata));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [23:0] scl(logic [23:0] v, logic [7:0] c);
		longint p;
		int sh;
		p = longint'($signed(v));
		sh = 4 - int'(c) / 12;
		if (c == 8'hff)
			return 24'h0;
		p = (sh >= 0) ? p <<< sh : p >>> (-sh);
		if (p > 64'sh7fffff)
			p = 64'sh7fffff;
		if (p < -64'sh800000)
			p = -64'sh800000;
		return p[23:0];
	endfunction
	task automatic cmp_smp(input string n, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_smp(n, {16'h0, e}, {16'h0, g});
	endtask
	task automatic cmp_flag(input string n, input logic e, input logic g);
		cmp_smp(n, {23'h0, e}, {23'h0, g});
	endtask
	task automatic results();
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		rq.push_back(e);
		@(negedge clk);
		rd = 1'b0;
	endtask
	task automatic do_reset();
		@(negedge clk);
		rst = 1'b1;
		fork
			src.pulse(5);
			repeat (12) @(negedge clk);
		join
		rst = 1'b0;
	endtask
	task automatic run_frames(input int n, input int cnt);
		logic [23:0] l, r, m, el, er;
		m = (vol > 8'h30 && vol != 8'hff) ? 24'hfe0000 : 24'hffffff;
		for (int k = 0; k < cnt; k++) begin
			l = 24'(rnd()) & m;
			r = 24'(rnd()) & m;
			src.send_frame(l, r, n);
			el = (lsrc == 2'h1) ? l : (lsrc == 2'h2) ? r : 24'h0;
			er = (rsrc == 2'h1) ? r : (rsrc == 2'h2) ? l : 24'h0;
			if (k < cnt - 1 && n >= 50)
				sq.push_back({scl(el, vol), scl(er, vol)});
		end
	endtask
	task automatic probe(input int n, input logic [3:0] md, input logic ig, input logic [7:0] e37,
		input logic [7:0] e38, input logic [1:0] b51);
		logic       err;
		logic [7:0] st;
		@(negedge clk);
		mode = md;
		ign = ig;
		{pll_en, pll_lock, pll_over} = 3'(rnd());
		err = (md == 4'h0) ? (e37[3:0] == 4'h0) : (e37[3:0] != md);
		st = {2'h0, b51[1], pll_over, pll_en & pll_lock, 1'b0, b51[0], err};
		fork
			run_frames(n, 4);
			begin
				repeat (n * 12 / 5) @(negedge clk);
				rd_reg(8'h37, e37);
				rd_reg(8'h38, e38);
				rd_reg(8'h39, st);
				cmp_flag("clock error", (err & !ig) | !b51[0], clkerr);
			end
		join
	endtask
	// read data and samples are matched against the oldest note
	always @(posedge clk) rd_seen <= rd && ce && !rst;
	always @(negedge clk) begin
		if (rd_seen === 1'b1 && rq.size() > 0)
			cmp_reg("read data", rq.pop_front(), rdata);
		if (ovalid === 1'b1 && sq.size() > 0) begin
			s = sq.pop_front();
			cmp_smp("left sample", s[47:24], lo);
			cmp_smp("right sample", s[23:0], ro);
		end
	end
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		results();
	end
	initial begin
		{rst, ce, wr, rd, pll_en, pll_lock, pll_over, ign} = 8'hc1;
		{addr, wdata, mode, lsrc, rsrc, vol} = {16'h0, 4'h0, 4'h5, 8'h30};
		do_reset();
		rd_reg(8'h35, 8'h11);
		rd_reg(8'h37, 8'h00);
		rd_reg(8'h38, 8'h00);
		rd_reg(8'h4c, 8'h30);
		rd_reg(8'h4e, 8'h33);
		rd_reg(8'h36, 8'h00);
		cmp_reg("ramp control", 8'h33, ramp);
		wr_reg(8'h4e, 8'h5a);
		cmp_reg("ramp control", 8'h5a, ramp);
		wr_reg(8'h38, 8'hff);
		wr_reg(8'h37, 8'hff);
		rd_reg(8'h38, 8'h00);
		rd_reg(8'h37, 8'hc0);
		wr_reg(8'h37, 8'h00);
		ce = 1'b0;
		wr_reg(8'h4c, 8'h00);
		ce = 1'b1;
		rd_reg(8'h4c, 8'h30);
		{pll_en, pll_lock, pll_over} = 3'b110;
		repeat (500) @(negedge clk);
		rd_reg(8'h39, 8'h0d);
		cmp_flag("clock error", 1'b1, clkerr);
		// every legal pair of source codes, never the reserved one
		for (int a = 0; a < 3; a++) begin
			for (int b = 0; b < 3; b++) begin
				{lsrc, rsrc} = {2'(a), 2'(b)};
				wr_reg(8'h35, {2'h0, lsrc, 2'h0, rsrc});
				rd_reg(8'h35, {2'h0, lsrc, 2'h0, rsrc});
				run_frames(64, 3);
			end
		end
		{lsrc, rsrc} = 4'h5;
		wr_reg(8'h35, 8'h11);
		foreach (vols[i]) begin
			vol = vols[i];
			wr_reg(8'h4c, vol);
			rd_reg(8'h4c, vol);
			run_frames(64, 3);
		end
		vol = 8'h30;
		wr_reg(8'h4c, vol);
		probe(217, 4'h0, 1'b0, 8'h0b, 8'hd9, 2'b01);
		probe(434, 4'h0, 1'b0, 8'h19, 8'hb2, 2'b01);
		probe(512, 4'h0, 1'b0, 8'h20, 8'h00, 2'b01);
		probe(32, 4'h0, 1'b0, 8'h00, 8'h20, 2'b01);
		probe(600, 4'h0, 1'b0, 8'h20, 8'h58, 2'b10);
		probe(217, 4'h9, 1'b0, 8'h0b, 8'hd9, 2'b01);
		probe(217, 4'h9, 1'b1, 8'h0b, 8'hd9, 2'b01);
		probe(217, 4'hb, 1'b0, 8'h0b, 8'hd9, 2'b01);
		do_reset();
		rd_reg(8'h4c, 8'h30);
		rd_reg(8'h35, 8'h11);
		repeat (2) @(negedge clk);
		cmp_reg("notes left over", 8'h00, 8'(rq.size() + sq.size()));
		results();
	end
endmodule // apr_route_clkmon_tb
